// ==== csf_defs.svh ====
// register offsets, field positions and reset values of the status bank
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH

// register offsets
`define CSF_OFS_SYSTEM_STATUS       8'h08
`define CSF_OFS_FAULT_REPORT        8'h09
`define CSF_OFS_INPUT_LIMIT         8'h0a
`define CSF_OFS_RESET_IDENTITY      8'h0b

// input_limit_status_mask fields
`define CSF_BIT_INPUT_ATTACHED      7
`define CSF_BIT_VLIM_ACTIVE         6
`define CSF_BIT_ILIM_ACTIVE         5
`define CSF_BIT_TOPOFF_RUNNING      3
`define CSF_BIT_INPUT_OV            2
`define CSF_BIT_VLIM_MASK           1
`define CSF_BIT_ILIM_MASK           0

// reset_and_identity fields
`define CSF_BIT_REG_RESET           7
`define CSF_MSB_PART_ID             6
`define CSF_LSB_PART_ID             3
`define CSF_MSB_REVISION            1

// reset values
`define CSF_RST_MASK                1'b0
`define CSF_RST_REG_RESET           1'b0

// i2c bit counting
`define CSF_BITS_PER_BYTE           4'h8
`define CSF_LAST_TX_BIT             4'h7

// source type and thermistor codes
`define CSF_SRC_NONE                3'h0
`define CSF_SRC_UNUSED              3'h4
`define CSF_NTC_NORMAL              3'h0
`define CSF_NTC_COLD                3'h5
`define CSF_NTC_HOT                 3'h6

`endif

// ==== csf_pkg.sv ====
// types shared by the charger status and fault register bank
`default_nettype none

package csf_pkg;

    // live conditions reported by the charger core
    typedef struct packed {
        logic [2:0] input_source_type;
        logic [1:0] charge_phase;
        logic       power_good_flag;
        logic       thermal_regulation_flag;
        logic       min_system_voltage_flag;
        logic       watchdog_expired;
        logic       boost_fault;
        logic [1:0] charge_fault_code;
        logic       battery_overvoltage_flag;
        logic [2:0] thermistor_zone_code;
        logic       boost_mode;
        logic       input_attached_flag;
        logic       input_voltage_limit_active;
        logic       input_current_limit_active;
        logic       topoff_timer_running;
        logic       input_overvoltage_flag;
    } csf_status_t;

    // serial interface states
    typedef enum logic [3:0] {
        CSF_IDLE   = 4'h0,
        CSF_ADDR   = 4'h1,
        CSF_ACK_A  = 4'h2,
        CSF_REG    = 4'h3,
        CSF_ACK_W  = 4'h4,
        CSF_WRITE  = 4'h5,
        CSF_READ   = 4'h6,
        CSF_RACK   = 4'h7
    } csf_state_t;

endpackage : csf_pkg

`default_nettype wire

// ==== csf_regs.sv ====
// charger status and fault registers behind an i2c target port
//
// Notes on behaviour
// - source type three bits: none, sdp, cdp, dcp, unknown, other, otg.
// - charge phase two bits: idle, pre-charge, fast, terminated.
// - power good, thermal and minimum system flags follow live conditions.
// - watchdog fault bit reads 1 after watchdog expiry, else 0.
// - boost fault bit set whenever the boost output cannot run.
// - charge fault code: normal, input fault, thermal shutdown, safety timer.
// - battery fault bit reads 1 on battery overvoltage, else 0.
// - in charging mode thermistor zone codes normal, warm, cool, cold, hot.
// - in boost mode only normal, cold and hot thermistor codes appear.
// - register 0x0a bit 7 shows input attached, bit 2 input overvoltage.
// - input voltage limit status bit follows voltage regulation activity.
// - input current limit status bit follows current regulation activity.
// - top-off status bit reads 1 while the top-off timer counts.
// - voltage limit mask bit suppresses its interrupt pulse; resets to 0.
// - current limit mask bit suppresses its interrupt pulse; resets to 0.
// - register 0x0b: reset control, part identifier, reserved, revision.
// - reset control restores defaults, resets safety timer, self-clears.
`include "csf_defs.svh"
`default_nettype none

module csf_regs #(
    parameter logic [6:0] TARGET_ADDR = 7'h2a, // arbitrary bus address
    parameter logic [3:0] PART_ID     = 4'h5,  // arbitrary value
    parameter logic [1:0] REVISION    = 2'h1   // arbitrary value
) (
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 scl_i,
    input  wire logic                 sda_i,
    output var  logic                 sda_o,
    output var  logic                 sda_oe_n_o,
    input  wire csf_pkg::csf_status_t status_i,
    output var  logic                 irq_pulse_o,
    output var  logic                 safety_timer_reset_o
);

    // =========================================================================
    // state
    // =========================================================================
    logic                scl_ff;
    logic                sda_ff;
    csf_pkg::csf_state_t state_ff;
    logic [3:0]          bit_cnt_ff;
    logic [7:0]          shift_ff;
    logic [7:0]          ptr_ff;
    logic                rw_ff;
    logic                oe_n_ff;
    logic                sda_out_ff;
    logic                vlim_mask_ff;
    logic                ilim_mask_ff;
    logic                reg_reset_ff;
    logic                timer_reset_ff;
    logic                vlim_prev_ff;
    logic                ilim_prev_ff;
    logic                irq_ff;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic byte_done;
    logic wr_strobe;
    logic vlim_edge;
    logic ilim_edge;

    // =========================================================================
    // field cleaning
    // =========================================================================
    // code 100 is not a defined source, report it as no input
    function automatic logic [2:0] clean_source(input logic [2:0] code);
        clean_source = (code == `CSF_SRC_UNUSED) ? `CSF_SRC_NONE : code;
    endfunction

    // boost mode knows only normal, cold and hot
    function automatic logic [2:0] clean_zone(input logic [2:0] code,
                                              input logic       boost);
        logic ok;
        ok = (code == `CSF_NTC_NORMAL) || (code == `CSF_NTC_COLD)
          || (code == `CSF_NTC_HOT);
        clean_zone = (boost && !ok) ? `CSF_NTC_NORMAL : code;
    endfunction

    // =========================================================================
    // read data
    // =========================================================================
    // sampled when the byte is loaded, so the host sees the live condition
    function automatic logic [7:0] read_byte(input logic [7:0]           ofs,
                                             input csf_pkg::csf_status_t s,
                                             input logic                 vm,
                                             input logic                 im,
                                             input logic                 rr);
        read_byte = 8'h00;
        unique case (ofs)
            `CSF_OFS_SYSTEM_STATUS: begin
                read_byte = {clean_source(s.input_source_type),
                             s.charge_phase, s.power_good_flag,
                             s.thermal_regulation_flag,
                             s.min_system_voltage_flag};
            end
            `CSF_OFS_FAULT_REPORT: begin
                read_byte = {s.watchdog_expired, s.boost_fault,
                             s.charge_fault_code, s.battery_overvoltage_flag,
                             clean_zone(s.thermistor_zone_code,
                                        s.boost_mode)};
            end
            `CSF_OFS_INPUT_LIMIT: begin
                read_byte[`CSF_BIT_INPUT_ATTACHED] = s.input_attached_flag;
                read_byte[`CSF_BIT_INPUT_OV]       = s.input_overvoltage_flag;
                read_byte[`CSF_BIT_VLIM_ACTIVE] = s.input_voltage_limit_active;
                read_byte[`CSF_BIT_ILIM_ACTIVE] = s.input_current_limit_active;
                read_byte[`CSF_BIT_TOPOFF_RUNNING] = s.topoff_timer_running;
                read_byte[`CSF_BIT_VLIM_MASK]      = vm;
                read_byte[`CSF_BIT_ILIM_MASK]      = im;
            end
            `CSF_OFS_RESET_IDENTITY: begin
                read_byte[`CSF_BIT_REG_RESET] = rr;
                read_byte[`CSF_MSB_PART_ID:`CSF_LSB_PART_ID] = PART_ID;
                read_byte[`CSF_MSB_REVISION:0] = REVISION;
            end
            default: read_byte = 8'h00;
        endcase
    endfunction

    // =========================================================================
    // bus line sampling
    // =========================================================================
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_ff <= scl_i;
            sda_ff <= sda_i;
        end
    end

    assign scl_rise   = scl_i && !scl_ff;
    assign scl_fall   = !scl_i && scl_ff;
    assign start_seen = scl_i && scl_ff && sda_ff && !sda_i;
    assign stop_seen  = scl_i && scl_ff && !sda_ff && sda_i;
    assign byte_done  = scl_fall && (bit_cnt_ff == `CSF_BITS_PER_BYTE);
    assign wr_strobe  = (state_ff == csf_pkg::CSF_WRITE) && byte_done;

    // =========================================================================
    // serial protocol
    // =========================================================================
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff   <= csf_pkg::CSF_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 8'h00;
            rw_ff      <= 1'b0;
            oe_n_ff    <= 1'b1;
        end else if (start_seen) begin
            state_ff   <= csf_pkg::CSF_ADDR;
            bit_cnt_ff <= 4'h0;
            oe_n_ff    <= 1'b1;
        end else if (stop_seen) begin
            state_ff <= csf_pkg::CSF_IDLE;
            oe_n_ff  <= 1'b1;
        end else begin
            unique case (state_ff)
                csf_pkg::CSF_IDLE: begin
                    oe_n_ff <= 1'b1;
                end
                csf_pkg::CSF_ADDR, csf_pkg::CSF_REG,
                csf_pkg::CSF_WRITE: begin
                    if (scl_rise) begin
                        shift_ff   <= {shift_ff[6:0], sda_i};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        if (state_ff != csf_pkg::CSF_ADDR) begin
                            oe_n_ff  <= 1'b0;
                            state_ff <= csf_pkg::CSF_ACK_W;
                        end else if (shift_ff[7:1] == TARGET_ADDR) begin
                            oe_n_ff  <= 1'b0;
                            rw_ff    <= shift_ff[0];
                            state_ff <= csf_pkg::CSF_ACK_A;
                        end else begin
                            state_ff <= csf_pkg::CSF_IDLE;
                        end
                    end
                end
                csf_pkg::CSF_ACK_A: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        if (rw_ff) begin
                            shift_ff <= {read_byte(ptr_ff, status_i,
                                vlim_mask_ff, ilim_mask_ff,
                                reg_reset_ff)} << 1;
                            oe_n_ff  <= read_byte(ptr_ff, status_i,
                                vlim_mask_ff, ilim_mask_ff,
                                reg_reset_ff) >> 7 != 8'h00;
                            state_ff <= csf_pkg::CSF_READ;
                        end else begin
                            oe_n_ff  <= 1'b1;
                            state_ff <= csf_pkg::CSF_REG;
                        end
                    end
                end
                csf_pkg::CSF_ACK_W: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        oe_n_ff    <= 1'b1;
                        state_ff   <= csf_pkg::CSF_WRITE;
                    end
                end
                csf_pkg::CSF_READ: begin
                    if (scl_fall) begin
                        if (bit_cnt_ff == `CSF_LAST_TX_BIT) begin
                            oe_n_ff  <= 1'b1;
                            state_ff <= csf_pkg::CSF_RACK;
                        end else begin
                            oe_n_ff    <= shift_ff[7];
                            shift_ff   <= {shift_ff[6:0], 1'b0};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                end
                csf_pkg::CSF_RACK: begin
                    // a released line at the ack slot ends the read burst
                    if (scl_rise && sda_i) begin
                        state_ff <= csf_pkg::CSF_IDLE;
                    end else if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        shift_ff   <= {read_byte(ptr_ff, status_i,
                            vlim_mask_ff, ilim_mask_ff,
                            reg_reset_ff)} << 1;
                        oe_n_ff    <= read_byte(ptr_ff, status_i,
                            vlim_mask_ff, ilim_mask_ff,
                            reg_reset_ff) >> 7 != 8'h00;
                        state_ff   <= csf_pkg::CSF_READ;
                    end
                end
                default: begin
                    state_ff <= csf_pkg::CSF_IDLE;
                end
            endcase
        end
    end

    // =========================================================================
    // register pointer
    // =========================================================================
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ptr_ff <= 8'h00;
        end else if ((state_ff == csf_pkg::CSF_REG) && byte_done) begin
            ptr_ff <= shift_ff;
        end else if (wr_strobe) begin
            ptr_ff <= ptr_ff + 8'h01;
        end else if ((state_ff == csf_pkg::CSF_RACK) && scl_rise
                     && !sda_i) begin
            ptr_ff <= ptr_ff + 8'h01;
        end
    end

    // =========================================================================
    // writable bits
    // =========================================================================
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            vlim_mask_ff <= `CSF_RST_MASK;
            ilim_mask_ff <= `CSF_RST_MASK;
        end else if (reg_reset_ff) begin
            vlim_mask_ff <= `CSF_RST_MASK;
            ilim_mask_ff <= `CSF_RST_MASK;
        end else if (wr_strobe && (ptr_ff == `CSF_OFS_INPUT_LIMIT)) begin
            vlim_mask_ff <= shift_ff[`CSF_BIT_VLIM_MASK];
            ilim_mask_ff <= shift_ff[`CSF_BIT_ILIM_MASK];
        end
    end

    // the reset control reads 1 for one cycle only: defaults land next edge
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_reset_ff   <= `CSF_RST_REG_RESET;
            timer_reset_ff <= 1'b0;
        end else begin
            reg_reset_ff   <= wr_strobe
                && (ptr_ff == `CSF_OFS_RESET_IDENTITY)
                && shift_ff[`CSF_BIT_REG_RESET];
            timer_reset_ff <= reg_reset_ff;
        end
    end

    // =========================================================================
    // interrupt pulse
    // =========================================================================
    assign vlim_edge = status_i.input_voltage_limit_active && !vlim_prev_ff;
    assign ilim_edge = status_i.input_current_limit_active && !ilim_prev_ff;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            vlim_prev_ff <= 1'b0;
            ilim_prev_ff <= 1'b0;
            irq_ff       <= 1'b0;
        end else begin
            vlim_prev_ff <= status_i.input_voltage_limit_active;
            ilim_prev_ff <= status_i.input_current_limit_active;
            irq_ff <= (vlim_edge && !vlim_mask_ff)
                   || (ilim_edge && !ilim_mask_ff);
        end
    end

    // open-drain: only ever pulls low
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sda_out_ff <= 1'b0;
        end else begin
            sda_out_ff <= 1'b0;
        end
    end

    assign sda_o                = sda_out_ff;
    assign sda_oe_n_o           = oe_n_ff;
    assign irq_pulse_o          = irq_ff;
    assign safety_timer_reset_o = timer_reset_ff;

endmodule // csf_regs

`default_nettype wire

// ==== csf_regs_properties.sv ====
// concurrent checks on the ports of the status register bank
`default_nettype none

module csf_regs_checker (
    input wire logic                 clk_i,
    input wire logic                 reset_i,
    input wire logic                 scl_i,
    input wire logic                 sda_i,
    input wire logic                 sda_o,
    input wire logic                 sda_oe_n_o,
    input wire csf_pkg::csf_status_t status_i,
    input wire logic                 irq_pulse_o,
    input wire logic                 safety_timer_reset_o
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic vlim = status_i.input_voltage_limit_active;
    wire logic ilim = status_i.input_current_limit_active;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // ==========================
    // serial line steps
    sequence s_ack_open;
        $fell(sda_oe_n_o) && !scl_i;
    endsequence
    sequence s_stop_seen;
        $rose(sda_i) && scl_i && $past(scl_i);
    endsequence
    a_sda_never_high: assert property (sda_o == 1'b0)
        else $error("data output driven high");
    a_drive_low_scl: assert property ($changed(sda_oe_n_o) |->
        !scl_i && !$past(scl_i)) else $error("drive moved with clock high");
    a_drive_holds: assert property (s_ack_open |=> !sda_oe_n_o [*2])
        else $error("low drive released too soon");
    a_stop_released: assert property (s_stop_seen |=> sda_oe_n_o [*3])
        else $error("line driven after stop");
    a_irq_cause: assert property (irq_pulse_o |->
        ($past(vlim) && !$past(vlim, 2)) || ($past(ilim) && !$past(ilim, 2)))
        else $error("interrupt without limit entry");
    a_timer_single: assert property (safety_timer_reset_o |=>
        !safety_timer_reset_o) else $error("timer reset too long");
    a_timer_on_ack: assert property (safety_timer_reset_o |->
        !sda_oe_n_o && $past(sda_oe_n_o, 2))
        else $error("timer reset off ack");
    a_reset_quiet: assert property ($fell(reset_i) |-> sda_oe_n_o &&
        !irq_pulse_o && !safety_timer_reset_o) else $error("busy after reset");
endmodule // csf_regs_checker

bind csf_regs csf_regs_checker u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .status_i(status_i),
    .irq_pulse_o(irq_pulse_o), .safety_timer_reset_o(safety_timer_reset_o));

`default_nettype wire

// ==== csf_host_model.sv ====
// serial bus controller model standing in for the host processor
`default_nettype none

module csf_host_model (
    input  wire logic clk_i,
    input  wire logic dev_sda_i,
    input  wire logic dev_oe_n_i,
    output var  logic scl_o,
    output wire logic sda_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic host_sda;
    logic got_ack;
    logic addr_ack;
    // ==========================
    // pulled-up data line: high unless someone pulls it low
    assign sda_o = host_sda & (dev_oe_n_i | dev_sda_i);
    initial begin
        scl_o = 1'b1;
        host_sda = 1'b1;
        got_ack = 1'b0;
        addr_ack = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // a=1 gives start or repeated start, a=0 gives stop
    task automatic cond(input logic a);
        tick(1);
        host_sda <= a;
        tick(2);
        scl_o <= 1'b1;
        tick(3);
        host_sda <= ~a;
        tick(3);
        scl_o <= ~a;
    endtask
    // clock low and high phases last three cycles each, above two
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        host_sda <= b;
        tick(2);
        scl_o <= 1'b1;
        tick(2);
        r = sda_o;
        tick(1);
        scl_o <= 1'b0;
    endtask
    // ninth bit always released: ack slot on writes, nack on reads
    task automatic byte_io(input logic [7:0] d, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(1'b1, a);
        got_ack = !a;
    endtask
    task automatic xfer(input logic [6:0] a, input logic [7:0] o,
                        input logic rd, inout logic [7:0] d);
        logic [7:0] r;
        cond(1'b1);
        byte_io({a, 1'b0}, r);
        addr_ack = got_ack;
        byte_io(o, r);
        if (rd) begin
            cond(1'b1);
            byte_io({a, 1'b1}, r);
        end
        byte_io(rd ? 8'hff : d, r);
        cond(1'b0);
        if (rd)
            d = r;
    endtask
endmodule // csf_host_model

`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the charger status and fault register bank
`default_nettype none

`define CHK(nm, e, g) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("wrong value %s exp %0h got %0h", nm, e, g); \
    end \
end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] ADR = 7'h2a;
    localparam logic [3:0] PID = 4'h9; // arbitrary value
    localparam logic [1:0] REV = 2'h2; // arbitrary value
    localparam logic [7:0] IDV = {1'b0, PID, 1'b0, REV};
    logic                 clk_i = 1'b0;
    logic                 reset_i = 1'b1;
    logic                 scl, sda, dev_sda, dev_oe_n, irq, tmr;
    csf_pkg::csf_status_t st = '0;
    int                   bad_count = 0, total_checks = 0;
    int                   cycles = 0, irq_n = 0, tmr_n = 0;
    always #50 clk_i = ~clk_i;
    csf_regs #(.TARGET_ADDR(ADR), .PART_ID(PID), .REVISION(REV)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda),
        .sda_o(dev_sda), .sda_oe_n_o(dev_oe_n), .status_i(st),
        .irq_pulse_o(irq), .safety_timer_reset_o(tmr));
    csf_host_model host (.clk_i(clk_i), .dev_sda_i(dev_sda),
        .dev_oe_n_i(dev_oe_n), .scl_o(scl), .sda_o(sda));
    // ==========================
    // pulse counting and hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (irq === 1'b1) irq_n++;
        if (tmr === 1'b1) tmr_n++;
        if (cycles == 30000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic set_st(input csf_pkg::csf_status_t v);
        @(posedge clk_i);
        st <= v;
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        host.xfer(ADR, o, 1'b0, d);
    endtask
    task automatic chk_rd(input logic [7:0] o, input logic [7:0] e);
        logic [7:0] d;
        host.xfer(ADR, o, 1'b1, d);
        `CHK($sformatf("reg %h", o), e, d)
    endtask
    // ==========================
    // scenarios
    task automatic t_ident();
        logic [7:0] d = 8'h03;
        chk_rd(8'h0b, IDV);
        chk_rd(8'h0a, 8'h00);
        chk_rd(8'h20, 8'h00);
        host.xfer(ADR + 7'h01, 8'h0a, 1'b0, d);
        `CHK("foreign ack", 1'b0, host.addr_ack)
        chk_rd(8'h0a, 8'h00);
    endtask
    task automatic t_system();
        csf_pkg::csf_status_t v;
        logic [2:0] src;
        for (int i = 0; i < 8; i++) begin
            v = '0;
            v.input_source_type = 3'(i);
            v.charge_phase = 2'(i);
            v.power_good_flag = i[0];
            v.thermal_regulation_flag = i[1];
            v.min_system_voltage_flag = i[2];
            set_st(v);
            src = (i == 4) ? 3'h0 : 3'(i);
            chk_rd(8'h08, {src, 2'(i), i[0], i[1], i[2]});
        end
    endtask
    task automatic t_fault();
        csf_pkg::csf_status_t v;
        logic [2:0] z;
        logic [2:0] zones [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6};
        for (int k = 0; k < 10; k++) begin
            v = '0;
            z = zones[k % 5];
            v.boost_mode = (k >= 5);
            v.thermistor_zone_code = z;
            v.watchdog_expired = k[0];
            v.boost_fault = k[1];
            v.charge_fault_code = 2'(k);
            v.battery_overvoltage_flag = k[2];
            set_st(v);
            if (k >= 5 && (z == 3'h2 || z == 3'h3))
                z = 3'h0;
            chk_rd(8'h09, {k[0], k[1], 2'(k), k[2], z});
        end
    endtask
    task automatic t_limits();
        csf_pkg::csf_status_t v = '0;
        wr(8'h0a, 8'hff);
        `CHK("ack", 1'b1, host.addr_ack)
        v.input_voltage_limit_active = 1'b1;
        v.topoff_timer_running = 1'b1;
        set_st(v);
        chk_rd(8'h0a, 8'h4b);
        wr(8'h0a, 8'h00);
        v = '0;
        v.input_attached_flag = 1'b1;
        v.input_current_limit_active = 1'b1;
        v.input_overvoltage_flag = 1'b1;
        set_st(v);
        chk_rd(8'h0a, 8'ha4);
        set_st('0);
    endtask
    task automatic lim_pulse(input logic vl, input logic il, input int e);
        csf_pkg::csf_status_t v = '0;
        int n0;
        n0 = irq_n;
        v.input_voltage_limit_active = vl;
        v.input_current_limit_active = il;
        set_st(v);
        repeat (4) @(posedge clk_i);
        set_st('0);
        repeat (4) @(posedge clk_i);
        `CHK("irq pulses", e, irq_n - n0)
    endtask
    task automatic t_irq();
        lim_pulse(1'b1, 1'b0, 1);
        lim_pulse(1'b0, 1'b1, 1);
        wr(8'h0a, 8'h02);
        lim_pulse(1'b1, 1'b0, 0);
        lim_pulse(1'b0, 1'b1, 1);
        wr(8'h0a, 8'h01);
        lim_pulse(1'b1, 1'b0, 1);
        lim_pulse(1'b0, 1'b1, 0);
    endtask
    task automatic t_regrst();
        int n0;
        wr(8'h0a, 8'h03);
        n0 = tmr_n;
        wr(8'h0b, 8'h7f);
        `CHK("timer resets", n0, tmr_n)
        chk_rd(8'h0b, IDV);
        wr(8'h0b, 8'h80);
        `CHK("timer resets", n0 + 1, tmr_n)
        chk_rd(8'h0b, IDV);
        chk_rd(8'h0a, 8'h00);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_ident();
        t_system();
        t_fault();
        t_limits();
        t_irq();
        t_regrst();
        test_done();
    end
endmodule // tb_top

`default_nettype wire
